// >>> fmo_pkg.sv
package fmo_pkg;

  // Register offsets (word index on the plain register port)
  localparam logic [3:0] OFS_SPEED_REF   = 4'h0;
  localparam logic [3:0] OFS_CONFIG      = 4'h1;
  localparam logic [3:0] OFS_PID_SP      = 4'h2;
  localparam logic [3:0] OFS_AUTORESET   = 4'h3;
  localparam logic [3:0] OFS_NORMAL_AR   = 4'h4;
  localparam logic [3:0] OFS_STATUS      = 4'h5;
  localparam logic [3:0] OFS_OPSTATE     = 4'h6;
  localparam logic [3:0] OFS_LOG         = 4'h7;
  localparam logic [3:0] OFS_CONTROL     = 4'h8;

  // Reset values and speed reference limit
  localparam logic [15:0] RST_SPEED_REF  = 16'h0000;
  localparam logic [15:0] RST_CONFIG     = 16'h0000;
  localparam logic [15:0] RST_PID_SP     = 16'h0000;
  localparam logic [15:0] RST_AUTORESET  = 16'h0000;
  localparam logic [15:0] RST_NORMAL_AR  = 16'h0000;
  localparam logic [15:0] SPEED_REF_MAX  = 16'h4650;

  // Fire-mode configuration codes
  localparam logic [2:0] CFG_DISABLED  = 3'h0;
  localparam logic [2:0] CFG_KEEP      = 3'h1;
  localparam logic [2:0] CFG_SPEED     = 3'h2;
  localparam logic [2:0] CFG_PID       = 3'h3;
  localparam logic [2:0] CFG_COAST     = 3'h4;

  // Operating-state indication codes
  localparam logic [3:0] OPST_NORMAL   = 4'h0;
  localparam logic [3:0] OPST_FIRE     = 4'h1;

  // Status field positions
  localparam int STAT_FIRE     = 0;
  localparam int STAT_ALARM    = 1;
  localparam int STAT_SECOND   = 2;
  localparam int STAT_OUTEN    = 3;
  localparam int STAT_FAULT    = 4;

  // Control field positions
  localparam int CTRL_ESC      = 0;
  localparam int CTRL_FLTRST   = 1;
  localparam int CTRL_LOGCLR   = 2;

  // Critical fault indices
  localparam int FLT_DCOV      = 0;
  localparam int FLT_OVCUR     = 1;
  localparam int FLT_SAFESTOP  = 2;
  localparam int FLT_CRIT_N    = 3;

  // Timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int AUTORESET_MS  = 1000;
  localparam int AUTORESET_CYC = CLK_HZ / 1000 * AUTORESET_MS;

  typedef struct packed {
    logic       alarm;
    logic       alarm_secondary;
    logic [3:0] op_state;
  } fmo_display_s;

  typedef struct packed {
    logic [15:0] speed_ref;
    logic [15:0] pid_sp;
    logic        speed_sel;
    logic        pid_sel;
  } fmo_ref_s;

endpackage

// >>> fmo_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fmo_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Asynchronous levels and filtered result
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] init_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) $error("fmo_sync width must be positive");
  end

  always_ff @(posedge clk_sys_in) begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Change accepted only once two late stages agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        level_out[i] <= init_in[i];
      end else if (s2_q[i] == s3_q[i]) begin
        level_out[i] <= s3_q[i];
      end
    end
  end

endmodule

`default_nettype wire

// >>> fmo_fire_mode.sv
// Behaviour
// - Enter fire mode while fire input is low and configuration enables it
// - On entry raise fire alarm and show fire in operating state
// - Escape moves alarm to secondary line, operating state unchanged
// - Fire digital output asserted throughout fire mode
// - In fire mode ignore stops and enable removal, except safety stop
// - In fire mode suppress ordinary protective faults
// - Overvoltage, overcurrent and safety-stop faults stay active, auto-resettable
// - Configuration two drives motor to fire speed reference, max 18000 rpm
// - Configuration zero keeps fire function inactive, input ignored
// - Configuration one alarms but keeps present reference and setpoint
// - Configuration three replaces PID setpoint with fire setpoint
// - Configuration four alarms and disables output, motor coasts
// - Persistent record kept once fire mode has operated
// - Unlimited auto-reset clears critical fault 1 s after detection
`timescale 1ns/1ps
`default_nettype none

module fmo_fire_mode #(
  parameter int AUTORESET_CYCLES = fmo_pkg::AUTORESET_CYC,
  parameter int NUM_FAULTS       = 8
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  // Register port
  input  wire logic [3:0]            reg_addr_in,
  input  wire logic [15:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [15:0]           reg_rdata_out,
  // Pins
  input  wire logic                  fire_input_n_in,
  input  wire logic                  safety_stop_in,
  // Drive command inputs
  input  wire logic                  run_cmd_in,
  input  wire logic                  general_enable_in,
  input  wire logic [NUM_FAULTS-1:0] protect_fault_in,
  input  wire logic [2:0]            crit_fault_in,
  input  wire logic                  normal_fault_reset_in,
  input  wire logic [15:0]           speed_ref_in,
  input  wire logic [15:0]           pid_sp_in,
  // Drive outputs
  output logic                       fire_output_out,
  output logic                       output_enable_out,
  output logic                       fault_trip_out,
  output logic [15:0]                speed_ref_out,
  output logic [15:0]                pid_sp_out,
  output logic                       display_alarm_out,
  output logic                       display_secondary_out,
  output logic [3:0]                 operating_state_indication_out,
  output logic                       fire_logged_out
);

  localparam int CNT_W = $clog2(AUTORESET_CYCLES + 1);

  initial begin
    if (AUTORESET_CYCLES < 1) $error("fmo_fire_mode auto-reset count too small");
    if (NUM_FAULTS < 1) $error("fmo_fire_mode needs at least one fault");
  end

  typedef enum logic [1:0] {
    FMO_IDLE  = 2'b00,
    FMO_ENTER = 2'b01,
    FMO_FIRE  = 2'b11
  } fmo_state_e;

  // Registers
  logic [15:0]              fire_speed_reference_q;
  logic [15:0]              fire_mode_configuration_q;
  logic [15:0]              fire_pid_setpoint_q;
  logic [15:0]              fire_autoreset_configuration_q;
  logic [15:0]              normal_autoreset_setting_q;
  logic                     logged_q;
  logic                     secondary_q;
  fmo_state_e               state_q;
  fmo_state_e               state_d;
  logic [2:0]               crit_q;
  logic [CNT_W-1:0]         ar_cnt_q;
  logic                     fire_level;
  logic                     safety_level;
  logic                     in_fire;
  logic                     cfg_enabled;
  logic                     esc_pulse;
  logic                     fault_rst_pulse;
  logic                     log_clr_pulse;
  logic                     unlimited;
  logic                     any_protect;
  fmo_pkg::fmo_display_s    disp_d;
  fmo_pkg::fmo_ref_s        ref_d;

  // Pin inputs pass three stages; fire input idles high
  fmo_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   ({fire_input_n_in, safety_stop_in}),
    .init_in    (2'b10),
    .level_out  ({fire_level, safety_level})
  );

  assign cfg_enabled     = fire_mode_configuration_q[2:0] != fmo_pkg::CFG_DISABLED;
  assign in_fire         = (state_q == FMO_FIRE);
  assign unlimited       = fire_autoreset_configuration_q[0];
  assign any_protect     = |protect_fault_in;
  assign esc_pulse       = reg_wr_in && (reg_addr_in == fmo_pkg::OFS_CONTROL)
                           && reg_wdata_in[fmo_pkg::CTRL_ESC];
  assign fault_rst_pulse = reg_wr_in && (reg_addr_in == fmo_pkg::OFS_CONTROL)
                           && reg_wdata_in[fmo_pkg::CTRL_FLTRST];
  assign log_clr_pulse   = reg_wr_in && (reg_addr_in == fmo_pkg::OFS_CONTROL)
                           && reg_wdata_in[fmo_pkg::CTRL_LOGCLR];

  // Configuration registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fire_speed_reference_q         <= fmo_pkg::RST_SPEED_REF;
      fire_mode_configuration_q      <= fmo_pkg::RST_CONFIG;
      fire_pid_setpoint_q            <= fmo_pkg::RST_PID_SP;
      fire_autoreset_configuration_q <= fmo_pkg::RST_AUTORESET;
      normal_autoreset_setting_q     <= fmo_pkg::RST_NORMAL_AR;
    end else if (reg_wr_in) begin
      if (reg_addr_in == fmo_pkg::OFS_SPEED_REF) begin
        // Clamped to the top of the range
        fire_speed_reference_q <= (reg_wdata_in > fmo_pkg::SPEED_REF_MAX)
                                  ? fmo_pkg::SPEED_REF_MAX : reg_wdata_in;
      end else if (reg_addr_in == fmo_pkg::OFS_CONFIG) begin
        // Codes above four are refused
        if (reg_wdata_in <= 16'h0004) begin
          fire_mode_configuration_q <= reg_wdata_in;
        end
      end else if (reg_addr_in == fmo_pkg::OFS_PID_SP) begin
        fire_pid_setpoint_q <= reg_wdata_in;
      end else if (reg_addr_in == fmo_pkg::OFS_AUTORESET) begin
        fire_autoreset_configuration_q <= {15'h0000, reg_wdata_in[0]};
      end else if (reg_addr_in == fmo_pkg::OFS_NORMAL_AR) begin
        normal_autoreset_setting_q <= reg_wdata_in;
      end
    end
  end

  // Fire-mode state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      FMO_IDLE: begin
        if (!fire_level && cfg_enabled) begin
          state_d = FMO_ENTER;
        end
      end
      FMO_ENTER: begin
        state_d = FMO_FIRE;
      end
      FMO_FIRE: begin
        if (fire_level || !cfg_enabled) begin
          state_d = FMO_IDLE;
        end
      end
      default: begin
        state_d = FMO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= FMO_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Escape only moves the message; cleared on each new entry
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      secondary_q <= 1'b0;
    end else if (state_q == FMO_ENTER || !in_fire) begin
      secondary_q <= 1'b0;
    end else if (esc_pulse) begin
      secondary_q <= 1'b1;
    end
  end

  // Record survives leaving fire mode; only software clears it, entry wins
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      logged_q <= 1'b0;
    end else if (state_q == FMO_ENTER) begin
      logged_q <= 1'b1;
    end else if (log_clr_pulse) begin
      logged_q <= 1'b0;
    end
  end

  // Critical faults latch; timed reset in fire mode when unlimited
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      crit_q   <= 3'b000;
      ar_cnt_q <= '0;
    end else begin
      if (|crit_q && in_fire && unlimited) begin
        if (ar_cnt_q == CNT_W'(AUTORESET_CYCLES - 1)) begin
          crit_q   <= crit_fault_in;
          ar_cnt_q <= '0;
        end else begin
          crit_q   <= crit_q | crit_fault_in;
          ar_cnt_q <= ar_cnt_q + 1'b1;
        end
      end else begin
        ar_cnt_q <= '0;
        // New fault beats a simultaneous manual reset
        if (fault_rst_pulse || (normal_fault_reset_in && !(in_fire && unlimited))) begin
          crit_q <= crit_fault_in;
        end else begin
          crit_q <= crit_q | crit_fault_in;
        end
      end
    end
  end

  // Display and operating state
  always_comb begin
    disp_d.alarm           = in_fire && !secondary_q;
    disp_d.alarm_secondary = in_fire && secondary_q;
    disp_d.op_state        = in_fire ? fmo_pkg::OPST_FIRE : fmo_pkg::OPST_NORMAL;
  end

  // References per configuration
  always_comb begin
    ref_d.speed_sel = in_fire && (fire_mode_configuration_q[2:0] == fmo_pkg::CFG_SPEED);
    ref_d.pid_sel   = in_fire && (fire_mode_configuration_q[2:0] == fmo_pkg::CFG_PID);
    ref_d.speed_ref = ref_d.speed_sel ? fire_speed_reference_q : speed_ref_in;
    ref_d.pid_sp    = ref_d.pid_sel ? fire_pid_setpoint_q : pid_sp_in;
  end

  // Registered drive outputs
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fire_output_out                <= 1'b0;
      output_enable_out              <= 1'b0;
      fault_trip_out                 <= 1'b0;
      speed_ref_out                  <= 16'h0000;
      pid_sp_out                     <= 16'h0000;
      display_alarm_out              <= 1'b0;
      display_secondary_out          <= 1'b0;
      operating_state_indication_out <= fmo_pkg::OPST_NORMAL;
      fire_logged_out                <= 1'b0;
    end else begin
      fire_output_out                <= in_fire;
      speed_ref_out                  <= ref_d.speed_ref;
      pid_sp_out                     <= ref_d.pid_sp;
      display_alarm_out              <= disp_d.alarm;
      display_secondary_out          <= disp_d.alarm_secondary;
      operating_state_indication_out <= disp_d.op_state;
      fire_logged_out                <= logged_q;
      if (in_fire) begin
        // Ordinary protection masked, critical kept
        fault_trip_out    <= |crit_q;
        output_enable_out <= !safety_level && !(|crit_q)
                             && (fire_mode_configuration_q[2:0] != fmo_pkg::CFG_COAST);
      end else begin
        fault_trip_out    <= any_protect || |crit_q;
        output_enable_out <= run_cmd_in && general_enable_in && !safety_level
                             && !any_protect && !(|crit_q);
      end
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      if (reg_addr_in == fmo_pkg::OFS_SPEED_REF) begin
        reg_rdata_out <= fire_speed_reference_q;
      end else if (reg_addr_in == fmo_pkg::OFS_CONFIG) begin
        reg_rdata_out <= fire_mode_configuration_q;
      end else if (reg_addr_in == fmo_pkg::OFS_PID_SP) begin
        reg_rdata_out <= fire_pid_setpoint_q;
      end else if (reg_addr_in == fmo_pkg::OFS_AUTORESET) begin
        reg_rdata_out <= fire_autoreset_configuration_q;
      end else if (reg_addr_in == fmo_pkg::OFS_NORMAL_AR) begin
        reg_rdata_out <= normal_autoreset_setting_q;
      end else if (reg_addr_in == fmo_pkg::OFS_STATUS) begin
        reg_rdata_out <= {11'h000, |crit_q, output_enable_out, secondary_q,
                          in_fire && !secondary_q, in_fire};
      end else if (reg_addr_in == fmo_pkg::OFS_OPSTATE) begin
        reg_rdata_out <= {12'h000, disp_d.op_state};
      end else if (reg_addr_in == fmo_pkg::OFS_LOG) begin
        reg_rdata_out <= {15'h0000, logged_q};
      end else begin
        reg_rdata_out <= 16'h0000;
      end
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

// >>> fmo_fire_mode_props.sv
`timescale 1ns/1ps
`default_nettype none
module fmo_fire_mode_props #(
  parameter int AUTORESET_CYCLES = 20
) (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Watched inputs
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        fire_input_n_in,
  input wire logic        safety_stop_in,
  input wire logic [2:0]  crit_fault_in,
  input wire logic [15:0] speed_ref_in,
  // Watched outputs
  input wire logic        fire_output_out,
  input wire logic        output_enable_out,
  input wire logic        fault_trip_out,
  input wire logic [15:0] speed_ref_out,
  input wire logic        display_alarm_out,
  input wire logic        display_secondary_out,
  input wire logic [3:0]  operating_state_indication_out,
  input wire logic        fire_logged_out
);
  logic [15:0] cfg_q;
  logic [15:0] spd_q;
  logic        ar_q;
  logic [3:0]  safe_q;
  int          trip_q;
  // Shadow of written settings, registers are not visible here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_q <= '0;
      spd_q <= '0;
      ar_q <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == fmo_pkg::OFS_CONFIG && reg_wdata_in <= 16'h0004) cfg_q <= reg_wdata_in;
      if (reg_addr_in == fmo_pkg::OFS_SPEED_REF)
        spd_q <= (reg_wdata_in > fmo_pkg::SPEED_REF_MAX) ? fmo_pkg::SPEED_REF_MAX : reg_wdata_in;
      if (reg_addr_in == fmo_pkg::OFS_AUTORESET) ar_q <= reg_wdata_in[0];
    end
  end
  // Run lengths of stop relay (saturating at 4'hF) and fault indication (not saturating)
  always_ff @(posedge clk_sys_in) begin
    safe_q <= (rst_in || !safety_stop_in) ? 4'h0 : safe_q + 4'(safe_q != 4'hF);
    trip_q <= (rst_in || !fault_trip_out) ? 0 : trip_q + 1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  alarm_line_a: assert property (fire_output_out |-> display_alarm_out ^ display_secondary_out)
    else $error("fire mode without exactly one alarm line");
  opstate_fire_a: assert property ((operating_state_indication_out == fmo_pkg::OPST_FIRE) == fire_output_out)
    else $error("operating state disagrees with fire output");
  entry_cause_a: assert property ($rose(fire_output_out) |-> !$past(fire_input_n_in, 5) && cfg_q != 0)
    else $error("fire mode entered without low input and enabled setting");
  exit_pin_a: assert property (fire_input_n_in [*8] |=> !fire_output_out)
    else $error("fire mode held with input high");
  cfg_off_a: assert property (cfg_q == 16'h0000 [*4] |=> !fire_output_out)
    else $error("fire mode active while disabled");
  coast_a: assert property (fire_output_out && cfg_q == 16'h0004 |-> !output_enable_out)
    else $error("output enabled in coast setting");
  fire_speed_a: assert property (fire_output_out && cfg_q == 16'h0002 |-> speed_ref_out == spd_q)
    else $error("fire speed reference not applied");
  keep_ref_a: assert property (!$past(rst_in) && !(fire_output_out && cfg_q == 16'h0002) |-> speed_ref_out == $past(speed_ref_in))
    else $error("speed reference changed outside speed setting");
  protect_off_a: assert property (fire_output_out && $past(fire_output_out) && !$past(fault_trip_out)
    && crit_fault_in == 3'h0 && $past(crit_fault_in) == 3'h0 && $past(crit_fault_in, 2) == 3'h0 |-> !fault_trip_out)
    else $error("ordinary fault tripped in fire mode");
  safety_a: assert property (safe_q >= 4'h6 |-> !output_enable_out)
    else $error("safety stop did not disable output");
  autoreset_a: assert property (fire_output_out && ar_q && crit_fault_in == 3'h0 |-> trip_q <= AUTORESET_CYCLES + 4)
    else $error("critical fault not auto reset in time");
  log_a: assert property (fire_output_out |-> fire_logged_out)
    else $error("fire operation not recorded");
endmodule
bind fmo_fire_mode fmo_fire_mode_props #(.AUTORESET_CYCLES(AUTORESET_CYCLES)) fmo_fire_mode_props_inst (
  .clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .fire_input_n_in, .safety_stop_in,
  .crit_fault_in, .speed_ref_in, .fire_output_out, .output_enable_out, .fault_trip_out, .speed_ref_out,
  .display_alarm_out, .display_secondary_out, .operating_state_indication_out, .fire_logged_out);
`default_nettype wire

// >>> fmo_fire_contact.sv
`timescale 1ns/1ps
`default_nettype none
module fmo_fire_contact (
  // Clock
  input  wire logic clk_sys_in,
  // Alarm request and slow panel choice
  input  wire logic alarm_in,
  input  wire logic slow_in,
  // Contact, pulled high while closed
  output logic      fire_n_out
);
  int cnt_q = 0;
  initial fire_n_out = 1'b1;
  // Slow panels switch only after a delay, as relays in the field do
  always @(posedge clk_sys_in) begin
    if (alarm_in == fire_n_out) begin
      cnt_q <= cnt_q + 1;
      if (!slow_in || cnt_q >= 5) begin
        fire_n_out <= !alarm_in;
        cnt_q <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  localparam int AR = 20;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  reg_addr_in = '0;
  logic [15:0] reg_wdata_in = '0, speed_ref_in = '0, pid_sp_in = '0, lfsr_q = 16'h0037;
  logic        reg_wr_in = 0, reg_rd_in = 0, safety_stop_in = 0, run_cmd_in = 0;
  logic        general_enable_in = 0, normal_fault_reset_in = 0, alarm_req = 0, slow_req = 0;
  logic [7:0]  protect_fault_in = '0;
  logic [2:0]  crit_fault_in = '0;
  logic [15:0] reg_rdata_out, speed_ref_out, pid_sp_out;
  logic [3:0]  operating_state_indication_out;
  logic        fire_input_n_in, fire_output_out, output_enable_out, fault_trip_out;
  logic        display_alarm_out, display_secondary_out, fire_logged_out;
  int          fails = 0, n_tests = 0, cyc = 0, m_spd, i, j, c;
  logic        f;
  fmo_fire_mode #(.AUTORESET_CYCLES(AR)) fmo_fire_mode_inst (.clk_sys_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .fire_input_n_in, .safety_stop_in,
    .run_cmd_in, .general_enable_in, .protect_fault_in, .crit_fault_in, .normal_fault_reset_in,
    .speed_ref_in, .pid_sp_in, .fire_output_out, .output_enable_out, .fault_trip_out,
    .speed_ref_out, .pid_sp_out, .display_alarm_out, .display_secondary_out,
    .operating_state_indication_out, .fire_logged_out);
  fmo_fire_contact fmo_fire_contact_inst (.clk_sys_in, .alarm_in(alarm_req), .slow_in(slow_req),
    .fire_n_out(fire_input_n_in));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 `CHK(reg_rdata_out, e)
  endtask
  // Minimum wait first, so an entry that must not happen has time to show
  task automatic wt(input logic e);
    repeat (12) @(posedge clk_sys_in);
    for (i = 0; i < 30 && fire_output_out !== e; i++) @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (j = 0; j < 8; j++) rd(4'(j), 16'h0000);
    rd(4'hC, 16'h0000);
    wr(fmo_pkg::OFS_CONFIG, 16'h0005);
    rd(fmo_pkg::OFS_CONFIG, 16'h0000);
    wr(fmo_pkg::OFS_SPEED_REF, 16'hFFFF);
    rd(fmo_pkg::OFS_SPEED_REF, fmo_pkg::SPEED_REF_MAX);
    m_spd = 16'h1F40;
    wr(fmo_pkg::OFS_SPEED_REF, 16'(m_spd));
    wr(fmo_pkg::OFS_PID_SP, 16'hBEEF);
    for (c = 0; c < 5; c++) begin
      wr(fmo_pkg::OFS_CONFIG, 16'(c));
      f = (c != 0);
      lfsr_q = lfsr(lfsr_q);
      @(posedge clk_sys_in);
      speed_ref_in <= lfsr_q;
      pid_sp_in <= ~lfsr_q;
      general_enable_in <= lfsr_q[0];
      run_cmd_in <= lfsr_q[1];
      slow_req <= lfsr_q[2];
      alarm_req <= 1'b1;
      wt(f);
      @(posedge clk_sys_in);
      if (f) protect_fault_in <= lfsr_q[15:8];
      cycles(4);
      `CHK(fire_output_out, f)
      `CHK(operating_state_indication_out, f ? fmo_pkg::OPST_FIRE : fmo_pkg::OPST_NORMAL)
      `CHK(display_alarm_out, f)
      `CHK(speed_ref_out, c == 2 ? 16'(m_spd) : speed_ref_in)
      `CHK(pid_sp_out, c == 3 ? 16'hBEEF : pid_sp_in)
      if (f) begin
        `CHK(output_enable_out, c != 4)
        `CHK(fault_trip_out, 1'b0)
        rd(fmo_pkg::OFS_STATUS, c == 4 ? 16'h0003 : 16'h000B);
        wr(fmo_pkg::OFS_CONTROL, 16'h0001);
        cycles(3);
        `CHK(display_secondary_out, 1'b1)
        `CHK(operating_state_indication_out, fmo_pkg::OPST_FIRE)
      end else begin
        `CHK(output_enable_out, run_cmd_in && general_enable_in)
      end
      if (c == 2) begin
        wr(fmo_pkg::OFS_AUTORESET, 16'h0001);
        for (j = 0; j < 3; j++) begin
          @(posedge clk_sys_in) crit_fault_in <= 3'(1 << j);
          @(posedge clk_sys_in) crit_fault_in <= 3'h0;
          cycles(AR - 6);
          `CHK(fault_trip_out, 1'b1)
          `CHK(output_enable_out, 1'b0)
          cycles(9);
          `CHK(fault_trip_out, 1'b0)
        end
        wr(fmo_pkg::OFS_AUTORESET, 16'h0000);
        @(posedge clk_sys_in) crit_fault_in <= 3'h2;
        @(posedge clk_sys_in) crit_fault_in <= 3'h0;
        cycles(AR + 9);
        `CHK(fault_trip_out, 1'b1)
        @(posedge clk_sys_in) normal_fault_reset_in <= 1'b1;
        @(posedge clk_sys_in) normal_fault_reset_in <= 1'b0;
        cycles(4);
        `CHK(fault_trip_out, 1'b0)
        @(posedge clk_sys_in) safety_stop_in <= 1'b1;
        cycles(8);
        `CHK(output_enable_out, 1'b0)
        @(posedge clk_sys_in) safety_stop_in <= 1'b0;
        cycles(8);
        `CHK(output_enable_out, 1'b1)
      end
      @(posedge clk_sys_in);
      alarm_req <= 1'b0;
      protect_fault_in <= '0;
      wt(1'b0);
      `CHK(fire_output_out, 1'b0)
      `CHK(display_secondary_out, 1'b0)
      `CHK(fire_logged_out, f)
      wr(fmo_pkg::OFS_CONTROL, 16'h0004);
      rd(fmo_pkg::OFS_LOG, 16'h0000);
    end
    summarize();
  end
endmodule
`default_nettype wire
